/* fault_probe_pkg.sv */
// Purpose : constants and types for the channel fault probe controller
// Assumes : 100 MHz clock, four channels of a high-side switch
// Notes   : times kept in ns, cycle counts derived from the clock period
package fault_probe_pkg;

    localparam int          CHANNELS          = 4;
    localparam int          CLK_PERIOD_NS     = 10;

    // probe pulse width, centred inside the 3..6 us band
    localparam int          PROBE_WIDTH_NS    = 4500;
    localparam int          PROBE_MIN_NS      = 3000;
    localparam int          PROBE_MAX_NS      = 6000;
    localparam int          PROBE_SPACING_NS  = 200000;
    localparam int          RELEASE_DELAY_NS  = 8000;
    localparam int          RELEASE_WIN_MAX_NS = 150000;
    localparam int          STARTUP_SETTLE_NS = 90000;

    localparam int          PROBE_CYC   = PROBE_WIDTH_NS / CLK_PERIOD_NS;
    localparam int          SPACING_CYC = (PROBE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // listen from the end of the probe, when the pin goes high again, for delay plus the longest window
    localparam int          LISTEN_CYC  = (RELEASE_DELAY_NS + RELEASE_WIN_MAX_NS) / CLK_PERIOD_NS;
    localparam int          SETTLE_CYC  = (STARTUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int          CNT_W       = 16;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_PROBE  = 3'b010,
        ST_LISTEN = 3'b011,
        ST_GAP    = 3'b100
    } probe_state_type;

    typedef struct packed {
        logic [CHANNELS-1:0] faulty;
        logic                found;
        logic                unresolved;
        logic                busy;
    } diag_status_type;

endpackage

/* fault_probe_ctrl.sv */
// Purpose : host controller that drives four switch inputs and locates a faulty channel
// Assumes : fault flag pin arrives asynchronously, pulled up externally
// Notes   : user commands per channel; faulty channels are forced off when auto_off is set
`timescale 1ns/1ns
module fault_probe_ctrl
    import fault_probe_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // user side
    input  wire logic [CHANNELS-1:0]   channel_request,
    input  wire logic                  auto_off,
    input  wire logic                  fault_clear,
    output diag_status_type            diag_status,
    // switch pins
    output logic      [CHANNELS-1:0]   channel_input,
    input  wire logic                  fault_flag_pin
);

    // ****************************************
    // flag synchroniser
    // ****************************************
    logic                  flag_meta_r;
    logic                  flag_sync_r;
    logic                  flag_prev_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_meta_r <= 1'b1;
            flag_sync_r <= 1'b1;
            flag_prev_r <= 1'b1;
        end else begin
            flag_meta_r <= fault_flag_pin;
            flag_sync_r <= flag_meta_r;
            flag_prev_r <= flag_sync_r;
        end
    end

    logic flag_rise;
    assign flag_rise = flag_sync_r & ~flag_prev_r;

    // ****************************************
    // probe sequencer
    // ****************************************
    probe_state_type       state_r,   state_nxt;
    logic [CNT_W-1:0]      cnt_r,     cnt_nxt;
    logic [1:0]            ch_r,      ch_nxt;
    logic [CHANNELS-1:0]   active_r,  active_nxt;
    logic [CHANNELS-1:0]   faulty_r,  faulty_nxt;
    logic                  probed_r,  probed_nxt;
    logic                  unres_r,   unres_nxt;
    logic [CHANNELS-1:0]   req_prev_r, req_prev_nxt;
    logic [CHANNELS-1:0]   pins_r,    pins_nxt;

    // next active channel at or after ch_r, skipping channels that are off
    function automatic logic [2:0] next_active(input logic [CHANNELS-1:0] act, input logic [1:0] from);
        logic [2:0] res;
        logic [1:0] idx;
        res = 3'h4;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            idx = 2'(from + 2'(i));
            if (act[idx]) begin
                res = {1'b0, idx};
            end
        end
        return res;
    endfunction

    logic [2:0] nxt_ch;
    logic [CHANNELS-1:0] enabled;

    always_comb begin
        enabled      = channel_request & ~(faulty_r & {CHANNELS{auto_off}});
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        ch_nxt       = ch_r;
        active_nxt   = active_r;
        faulty_nxt   = faulty_r;
        probed_nxt   = probed_r;
        unres_nxt    = unres_r;
        req_prev_nxt = channel_request;
        nxt_ch       = next_active(active_r, ch_r);
        if (fault_clear) begin
            faulty_nxt = '0;
            unres_nxt  = 1'b0;
        end
        unique case (state_r)
            ST_IDLE: begin
                // a low flag starts a search; wait out start-up settling first
                if (!flag_sync_r && (channel_request & ~faulty_r) != '0) begin
                    active_nxt = enabled;
                    probed_nxt = 1'b0;
                    ch_nxt     = 2'h0;
                    cnt_nxt    = '0;
                    state_nxt  = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // start-up settle wait
                // a freshly switched-on channel may still be settling into its fault
                if ((channel_request & ~req_prev_r) != '0) begin
                    cnt_nxt = '0;
                end else if (cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
                    cnt_nxt = '0;
                    if (flag_sync_r) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        active_nxt = enabled;
                        ch_nxt     = 2'h0;
                        state_nxt  = ST_GAP;
                        cnt_nxt    = CNT_W'(SPACING_CYC - 1);
                    end
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_GAP: begin
                if (cnt_r != CNT_W'(SPACING_CYC - 1)) begin
                    cnt_nxt = cnt_r + 1'b1;
                end else if (nxt_ch[2]) begin
                    if (probed_r) begin
                        unres_nxt = 1'b1;
                    end
                    probed_nxt = 1'b0;
                    active_nxt = enabled;
                    ch_nxt     = 2'h0;
                    if (flag_sync_r || enabled == '0) begin
                        state_nxt = ST_IDLE;
                    end
                end else begin
                    ch_nxt    = nxt_ch[1:0];
                    cnt_nxt   = '0;
                    state_nxt = ST_PROBE;
                end
            end
            ST_PROBE: begin
                if (cnt_r == CNT_W'(PROBE_CYC - 1)) begin
                    state_nxt = ST_LISTEN;
                end
                cnt_nxt = cnt_r + 1'b1;
            end
            ST_LISTEN: begin
                if (flag_rise) begin
                    faulty_nxt[ch_r] = 1'b1;
                    unres_nxt        = 1'b0;
                    // silent probes earlier in this round must not mark it unresolved
                    probed_nxt       = 1'b0;
                    active_nxt       = '0;
                    state_nxt        = ST_GAP;
                end else if (cnt_r == CNT_W'(PROBE_CYC + LISTEN_CYC - 1)) begin
                    active_nxt[ch_r] = 1'b0;
                    probed_nxt       = 1'b1;
                    state_nxt        = ST_GAP;
                end
                cnt_nxt = cnt_r + 1'b1;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // faulty channel off when auto_off is set, probe inverts one pin
        pins_nxt = enabled;
        if (state_nxt == ST_PROBE) begin
            pins_nxt[ch_nxt] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= ST_IDLE;
            cnt_r      <= '0;
            ch_r       <= 2'h0;
            active_r   <= '0;
            faulty_r   <= '0;
            probed_r   <= 1'b0;
            unres_r    <= 1'b0;
            req_prev_r <= '0;
            pins_r     <= '0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            ch_r       <= ch_nxt;
            active_r   <= active_nxt;
            faulty_r   <= faulty_nxt;
            probed_r   <= probed_nxt;
            unres_r    <= unres_nxt;
            req_prev_r <= req_prev_nxt;
            pins_r     <= pins_nxt;
        end
    end

    // ****************************************
    // status register
    // ****************************************
    // built from the next values, so the flopped status lines up with the state registers
    diag_status_type       status_r,  status_nxt;

    always_comb begin
        status_nxt            = '0;
        status_nxt.faulty     = faulty_nxt;
        status_nxt.found      = faulty_nxt != '0;
        status_nxt.unresolved = unres_nxt;
        status_nxt.busy       = state_nxt != ST_IDLE;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign channel_input = pins_r;
    assign diag_status   = status_r;

endmodule

/* fault_probe_asserts.sv */
// Purpose: pin timing checks
// Assumes: 100 MHz clock
// Notes: probe = requested, not faulty, low, busy
`timescale 1ns/1ns
module fault_probe_asserts
    import fault_probe_pkg::*;
(
    // all ports of the controller
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic [CHANNELS-1:0] channel_request,
    input wire logic                auto_off,
    input wire logic                fault_clear,
    input wire diag_status_type     diag_status,
    input wire logic [CHANNELS-1:0] channel_input,
    input wire logic                fault_flag_pin
);
    logic [CHANNELS-1:0] probe_v;
    logic                probe_low;
    logic [15:0]         low_r;
    logic [15:0]         gap_r;
    assign probe_v   = channel_request & ~channel_input & ~diag_status.faulty;
    assign probe_low = diag_status.busy & (probe_v != 4'h0);
    // gap saturates so the first probe passes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_r <= 16'h0;
            gap_r <= 16'hFFFF;
        end else begin
            low_r <= probe_low ? low_r + 16'h1 : 16'h0;
            gap_r <= (probe_low && low_r == 16'h0) ? 16'h1 : gap_r + {15'h0, gap_r != 16'hFFFF};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_probe_end; $fell(probe_low); endsequence
    sequence s_flag_rise; $rose(fault_flag_pin); endsequence
    property p_one_probe; probe_low |-> $onehot(probe_v); endproperty
    property p_probe_min; s_probe_end |-> low_r >= 16'd300; endproperty
    property p_probe_max; probe_low |-> low_r < 16'd600; endproperty
    property p_spacing; (probe_low && low_r == 16'h0) |-> gap_r >= 16'd20000; endproperty
    property p_skip_off; (channel_input & ~$past(channel_request)) == 4'h0; endproperty
    property p_release; s_probe_end ##[1:1000] s_flag_rise |-> ##[1:6] diag_status.found; endproperty
    property p_cause; $rose(diag_status.found) |-> $past(fault_flag_pin, 2); endproperty
    property p_auto_off; (auto_off && diag_status.found) |=> (channel_input & $past(diag_status.faulty)) == 4'h0;
    endproperty
    a_one_probe: assert property (p_one_probe)
        else $error("two channels probed");
    a_probe_min: assert property (p_probe_min)
        else $error("probe too short");
    a_probe_max: assert property (p_probe_max)
        else $error("probe too long");
    a_spacing: assert property (p_spacing)
        else $error("probes too close");
    a_skip_off: assert property (p_skip_off)
        else $error("idle channel driven");
    a_release: assert property (p_release)
        else $error("release missed");
    a_cause: assert property (p_cause)
        else $error("fault without release");
    a_auto_off: assert property (p_auto_off)
        else $error("faulty channel left on");
endmodule
bind fault_probe_ctrl fault_probe_asserts fault_probe_asserts_inst (.clk(clk), .resetn(resetn),
    .channel_request(channel_request), .auto_off(auto_off), .fault_clear(fault_clear),
    .diag_status(diag_status), .channel_input(channel_input), .fault_flag_pin(fault_flag_pin));

/* switch_model.sv */
// Purpose: four channel switch, shared fault flag
// Assumes: bench picks shorted channels
// Notes: a short stands for both fault kinds
`timescale 1ns/1ns
module switch_model
    import fault_probe_pkg::*;
(
    // switch pins
    input  wire logic [CHANNELS-1:0] channel_input,
    output logic                     flag_oe,
    // fault injection
    input  wire logic [CHANNELS-1:0] short_ch
);
    logic [CHANNELS-1:0] channel_output;
    logic [CHANNELS-1:0] release_v;
    assign #6010 channel_output = channel_input;
    assign flag_oe = ((short_ch & channel_output) != 4'h0) && (release_v == 4'h0);
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        logic rel = 1'b0;
        assign release_v[i] = rel;
        always @(negedge channel_input[i]) begin
            if (short_ch[i]) begin
                #8000 rel = 1'b1;
                #80000 rel = 1'b0;
            end
        end
    end
endmodule

/* channel_fault_diagnosis_bench.sv */
// Purpose: locate one shorted channel
// Assumes: pull-up on the flag
// Notes: channels 0 and 1 random
`timescale 1ns/1ns
module channel_fault_diagnosis_bench
    import fault_probe_pkg::*;
;
    logic                clk, resetn, auto_off, fault_clear, flag_oe, fault_flag_pin, found_q;
    logic [CHANNELS-1:0] channel_request, channel_input, short_ch;
    diag_status_type     diag_status;
    logic [CHANNELS-1:0] exp_q[$];
    int                  error_cnt, samples_checked, seed, n;
    assign fault_flag_pin = flag_oe ? 1'b0 : 1'b1;
    fault_probe_ctrl fault_probe_ctrl_inst (.clk(clk), .resetn(resetn), .channel_request(channel_request),
        .auto_off(auto_off), .fault_clear(fault_clear), .diag_status(diag_status),
        .channel_input(channel_input), .fault_flag_pin(fault_flag_pin));
    switch_model switch_model_inst (.channel_input(channel_input), .flag_oe(flag_oe), .short_ch(short_ch));
    task check(input logic [CHANNELS-1:0] seen, input logic [CHANNELS-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ************
    // result watcher
    // ************
    // sampled on the falling edge, away from the launching edge
    always @(negedge clk) begin
        found_q <= diag_status.found;
        if (resetn && diag_status.found === 1'b1 && found_q === 1'b0) begin
            if (exp_q.size() == 0) check(diag_status.faulty, 4'h0);
            else check(diag_status.faulty, exp_q.pop_front());
        end
    end
    initial begin
        {error_cnt, samples_checked, seed} = {32'h0, 32'h0, 32'h61};
        {resetn, auto_off, fault_clear} = 3'h0;
        {channel_request, short_ch} = 8'h00;
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        step(1);
        channel_request = 4'hC | (4'($random(seed)) & 4'h3);
        auto_off = 1'b1;
        step(100);
        check(channel_input, channel_request);
        short_ch = 4'h4;
        exp_q.push_back(4'h4);
        n = 0;
        while (diag_status.found !== 1'b1 && n < 60000) begin
            step(1);
            n++;
        end
        if (n == 60000) begin
            error_cnt++;
        end else begin
            step(3);
            check(channel_input, channel_request & 4'hB);
            channel_request[2] = 1'b0;
            fault_clear = 1'b1;
            step(1);
            fault_clear = 1'b0;
            // the round runs out its probe spacing before going idle
            n = 0;
            while (diag_status.busy !== 1'b0 && n < 25000) begin
                step(1);
                n++;
            end
            if (n == 25000) error_cnt++;
            check({1'b0, diag_status.unresolved, diag_status.found, diag_status.busy}, 4'h0);
            // mid-run reset: pins off, then requests pass through again
            resetn = 1'b0;
            step(1);
            check(channel_input, 4'h0);
            resetn = 1'b1;
            step(2);
            check(channel_input, channel_request);
        end
        finish_test();
    end
endmodule
